// File: hw/adc_cfg_pkg.sv
package adc_cfg_pkg;
  // ****************************************
  // register map (word index = byte addr)
  // ****************************************
  localparam logic [3:0] ctrl0_addr     = 4'h0;
  localparam logic [3:0] ctrl1_addr     = 4'h1;
  localparam logic [3:0] porta_ans_addr = 4'h2;
  localparam logic [3:0] portb_ans_addr = 4'h3;
  localparam logic [3:0] dir_a_addr     = 4'h4;
  localparam logic [3:0] dir_b_addr     = 4'h5;
  localparam logic [3:0] lat_a_addr     = 4'h6;
  localparam logic [3:0] lat_b_addr     = 4'h7;
  localparam logic [3:0] port_a_addr    = 4'h8;
  localparam logic [3:0] port_b_addr    = 4'h9;
  localparam logic [3:0] irq_stat_addr  = 4'ha;
  localparam logic [3:0] irq_mask_addr  = 4'hb;
  localparam logic [3:0] result_addr    = 4'hc;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ctrl0_on_bit    = 0;
  localparam int ctrl0_start_bit = 1;
  localparam int ctrl0_chan_lsb  = 2;
  localparam int chan_width      = 5;
  localparam int nref_lsb        = 0;
  localparam int pref_lsb        = 2;
  localparam int ref_width       = 2;
  localparam int irq_done_bit    = 0;
  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic [7:0] ctrl_rst     = 8'h00;
  localparam logic [7:0] dir_rst      = 8'hff;
  localparam logic [7:0] ans_a_rst    = 8'hff;
  localparam logic [7:0] lat_rst      = 8'h00;
  localparam logic [1:0] pref_vdd     = 2'h0;
  localparam logic [1:0] pref_ext     = 2'h1;
  localparam logic [1:0] pref_fixed   = 2'h2;
  localparam logic [1:0] nref_gnd     = 2'h0;
  localparam logic [1:0] nref_ext     = 2'h1;
  localparam int         conv_cycles  = 24;
endpackage

// File: hw/adc_pin_sync.sv
`timescale 1ns/1ps
module adc_pin_sync #(
  parameter int width = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // pins
  input  wire logic [width-1:0] pin_in,
  output logic      [width-1:0] pin_sync
);
  logic [width-1:0] s1_ff;
  logic [width-1:0] s2_ff;
  logic [width-1:0] s3_ff;
  // a bit changes only once the 2nd and 3rd stages agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      pin_sync <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < width; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          pin_sync[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule

// File: hw/adc_ref_mux.sv
`timescale 1ns/1ps
module adc_ref_mux (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // selections
  input  wire logic [1:0] pref_sel,
  input  wire logic [1:0] nref_sel,
  // one-hot switch enables to the core
  output logic            pos_vdd_en,
  output logic            pos_fixed_en,
  output logic            pos_ext_en,
  output logic            neg_gnd_en,
  output logic            neg_ext_en
);
  // ****************************************
  // reference switches
  // ****************************************
  wire p_ext   = (pref_sel == adc_cfg_pkg::pref_ext);
  wire p_fixed = (pref_sel == adc_cfg_pkg::pref_fixed);
  wire n_ext   = (nref_sel == adc_cfg_pkg::nref_ext);
  // positive rail choice, unused code falls back to supply
  // negative choice, decoded apart from positive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_vdd_en   <= 1'b1;
      pos_fixed_en <= 1'b0;
      pos_ext_en   <= 1'b0;
      neg_gnd_en   <= 1'b1;
      neg_ext_en   <= 1'b0;
    end else begin
      pos_vdd_en   <= !(p_ext || p_fixed);
      pos_fixed_en <= p_fixed;
      pos_ext_en   <= p_ext;
      neg_gnd_en   <= !n_ext;
      neg_ext_en   <= n_ext;
    end
  end
endmodule

// File: hw/adc_input_and_reference_select.sv
// Functional notes
// - port read returns 0 on every pin with its analog select bit set.
// - conversion of selected pin ignores analog select and direction bits.
// - pin driven as output is sampled at the port's driven level.
// - channel select field routes one input to sample and hold.
// - two-bit positive reference field picks supply, fixed buffer or external.
// - two-bit negative reference field picks ground or external, independently.
// - config bit sets reset value of port b analog select bits.
// - on completion clear start bit, set interrupt flag, resume sampling.
`timescale 1ns/1ps
module adc_input_and_reference_select #(
  parameter int conv_len = adc_cfg_pkg::conv_cycles
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // nonvolatile configuration
  input  wire logic       portb_analog_reset_config,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // port pins
  input  wire logic [7:0] pa_in,
  input  wire logic [7:0] pb_in,
  output logic      [7:0] pa_out,
  output logic      [7:0] pa_oe,
  output logic      [7:0] pb_out,
  output logic      [7:0] pb_oe,
  output logic      [7:0] pa_dig_en,
  output logic      [7:0] pb_dig_en,
  // analog core
  output logic [4:0]      sh_channel,
  output logic            sh_sampling,
  output logic            core_drive_dig,
  output logic            core_dig_level,
  output logic            conv_busy,
  input  wire logic [9:0] core_result,
  output logic            pos_vdd_en,
  output logic            pos_fixed_en,
  output logic            pos_ext_en,
  output logic            neg_gnd_en,
  output logic            neg_ext_en,
  // interrupt
  output logic            irq
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] ans_a_ff;
  logic [7:0] ans_b_ff;
  logic [7:0] dir_a_ff;
  logic [7:0] dir_b_ff;
  logic [7:0] lat_a_ff;
  logic [7:0] lat_b_ff;
  logic [7:0] stat_ff;
  logic [7:0] mask_ff;
  logic [9:0] result_ff;
  logic [7:0] cnt_ff;
  logic       strap_done_ff;
  logic [7:0] pa_s;
  logic [7:0] pb_s;

  typedef enum logic [0:0] {sampling, converting} conv_state_type;
  conv_state_type state_ff;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  adc_pin_sync #(.width(8)) u_sync_a (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pin_in   (pa_in),
    .pin_sync (pa_s)
  );
  adc_pin_sync #(.width(8)) u_sync_b (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pin_in   (pb_in),
    .pin_sync (pb_s)
  );
  adc_ref_mux u_ref (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .pref_sel     (ctrl1_ff[adc_cfg_pkg::pref_lsb +: adc_cfg_pkg::ref_width]),
    .nref_sel     (ctrl1_ff[adc_cfg_pkg::nref_lsb +: adc_cfg_pkg::ref_width]),
    .pos_vdd_en   (pos_vdd_en),
    .pos_fixed_en (pos_fixed_en),
    .pos_ext_en   (pos_ext_en),
    .neg_gnd_en   (neg_gnd_en),
    .neg_ext_en   (neg_ext_en)
  );

  // ****************************************
  // decode
  // ****************************************
  wire        wr_c0   = reg_wr && hit(reg_addr, adc_cfg_pkg::ctrl0_addr);
  wire        wr_c1   = reg_wr && hit(reg_addr, adc_cfg_pkg::ctrl1_addr);
  wire        wr_aa   = reg_wr && hit(reg_addr, adc_cfg_pkg::porta_ans_addr);
  wire        wr_ab   = reg_wr && hit(reg_addr, adc_cfg_pkg::portb_ans_addr);
  wire        wr_da   = reg_wr && hit(reg_addr, adc_cfg_pkg::dir_a_addr);
  wire        wr_db   = reg_wr && hit(reg_addr, adc_cfg_pkg::dir_b_addr);
  wire        wr_la   = reg_wr && hit(reg_addr, adc_cfg_pkg::lat_a_addr);
  wire        wr_lb   = reg_wr && hit(reg_addr, adc_cfg_pkg::lat_b_addr);
  wire        wr_st   = reg_wr && hit(reg_addr, adc_cfg_pkg::irq_stat_addr);
  wire        wr_mk   = reg_wr && hit(reg_addr, adc_cfg_pkg::irq_mask_addr);
  wire [4:0]  chan    = ctrl0_ff[adc_cfg_pkg::ctrl0_chan_lsb +: adc_cfg_pkg::chan_width];
  wire        adc_on  = ctrl0_ff[adc_cfg_pkg::ctrl0_on_bit];
  wire        start   = ctrl0_ff[adc_cfg_pkg::ctrl0_start_bit];
  wire        done    = (state_ff == converting) && (cnt_ff == 8'h00);
  wire [7:0]  cnt_ld  = 8'(conv_len - 1);
  wire [7:0]  rd_pa   = pa_s & ~ans_a_ff;
  wire [7:0]  rd_pb   = pb_s & ~ans_b_ff;
  // output-driven pin is seen at its latch level
  wire        ch_port = chan[4];
  wire [2:0]  ch_bit  = chan[2:0];
  wire        ch_drv  = ch_port ? !dir_b_ff[ch_bit] : !dir_a_ff[ch_bit];
  wire        ch_lvl  = ch_port ? lat_b_ff[ch_bit] : lat_a_ff[ch_bit];
  wire [7:0]  nxt_stat = (stat_ff & ~(wr_st ? reg_wdata : 8'h00))
                         | {7'h00, done};
  logic [7:0] nxt_rdata;
  always_comb begin
    case (reg_addr)
      adc_cfg_pkg::ctrl0_addr:     nxt_rdata = ctrl0_ff;
      adc_cfg_pkg::ctrl1_addr:     nxt_rdata = ctrl1_ff;
      adc_cfg_pkg::porta_ans_addr: nxt_rdata = ans_a_ff;
      adc_cfg_pkg::portb_ans_addr: nxt_rdata = ans_b_ff;
      adc_cfg_pkg::dir_a_addr:     nxt_rdata = dir_a_ff;
      adc_cfg_pkg::dir_b_addr:     nxt_rdata = dir_b_ff;
      adc_cfg_pkg::lat_a_addr:     nxt_rdata = lat_a_ff;
      adc_cfg_pkg::lat_b_addr:     nxt_rdata = lat_b_ff;
      adc_cfg_pkg::port_a_addr:    nxt_rdata = rd_pa;
      adc_cfg_pkg::port_b_addr:    nxt_rdata = rd_pb;
      adc_cfg_pkg::irq_stat_addr:  nxt_rdata = stat_ff;
      adc_cfg_pkg::irq_mask_addr:  nxt_rdata = mask_ff;
      adc_cfg_pkg::result_addr:    nxt_rdata = result_ff[9:2];
      default:                     nxt_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // register file
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_ff  <= adc_cfg_pkg::ctrl_rst;
      ctrl1_ff  <= adc_cfg_pkg::ctrl_rst;
      ans_a_ff  <= adc_cfg_pkg::ans_a_rst;
      dir_a_ff  <= adc_cfg_pkg::dir_rst;
      dir_b_ff  <= adc_cfg_pkg::dir_rst;
      lat_a_ff  <= adc_cfg_pkg::lat_rst;
      lat_b_ff  <= adc_cfg_pkg::lat_rst;
      mask_ff   <= adc_cfg_pkg::ctrl_rst;
      stat_ff   <= adc_cfg_pkg::ctrl_rst;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_c0) begin
        ctrl0_ff <= reg_wdata;
      end
      if (done) begin
        ctrl0_ff[adc_cfg_pkg::ctrl0_start_bit] <= 1'b0;
      end
      if (wr_c1) begin
        ctrl1_ff <= reg_wdata;
      end
      if (wr_aa) begin
        ans_a_ff <= reg_wdata;
      end
      if (wr_da) begin
        dir_a_ff <= reg_wdata;
      end
      if (wr_db) begin
        dir_b_ff <= reg_wdata;
      end
      if (wr_la) begin
        lat_a_ff <= reg_wdata;
      end
      if (wr_lb) begin
        lat_b_ff <= reg_wdata;
      end
      if (wr_mk) begin
        mask_ff <= reg_wdata;
      end
      // set wins over a write-one clear
      stat_ff   <= nxt_stat;
      reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  // ****************************************
  // port b analog select with strap reset
  // ****************************************
  // async reset can only load a constant, so the strap is taken on the first edge
  // strap decides port b reset state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ans_b_ff      <= 8'h00;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      ans_b_ff      <= {8{portb_analog_reset_config}};
      strap_done_ff <= 1'b1;
    end else if (wr_ab) begin
      ans_b_ff <= reg_wdata;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  // settling after a channel change is left to software; no wait is enforced
  // settling wait is software's
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= sampling;
      cnt_ff    <= 8'h00;
      result_ff <= 10'h000;
    end else begin
      case (state_ff)
        sampling: begin
          if (adc_on && start) begin
            state_ff <= converting;
            cnt_ff   <= cnt_ld;
          end
        end
        converting: begin
          if (done) begin
            state_ff  <= sampling;
            result_ff <= core_result;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: state_ff <= sampling;
      endcase
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_out         <= 8'h00;
      pb_out         <= 8'h00;
      pa_oe          <= 8'h00;
      pb_oe          <= 8'h00;
      pa_dig_en      <= 8'h00;
      pb_dig_en      <= 8'h00;
      sh_channel     <= 5'h00;
      sh_sampling    <= 1'b0;
      core_drive_dig <= 1'b0;
      core_dig_level <= 1'b0;
      conv_busy      <= 1'b0;
      irq            <= 1'b0;
    end else begin
      pa_out         <= lat_a_ff;
      pb_out         <= lat_b_ff;
      pa_oe          <= ~dir_a_ff;
      pb_oe          <= ~dir_b_ff;
      pa_dig_en      <= ~ans_a_ff;
      pb_dig_en      <= ~ans_b_ff;
      // channel routed to sample and hold
      sh_channel     <= chan;
      // sampling never gated by select or direction bits
      sh_sampling    <= adc_on && (state_ff == sampling);
      // core told to sample the driven level
      core_drive_dig <= ch_drv;
      core_dig_level <= ch_lvl;
      conv_busy      <= state_ff == converting;
      irq            <= |(nxt_stat & mask_ff);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_port_read_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == adc_cfg_pkg::port_a_addr |=> (reg_rdata & $past(ans_a_ff)) == 8'h00)
    else $error("analog pin read not low");
  a_done_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done |=> stat_ff[adc_cfg_pkg::irq_done_bit] && !ctrl0_ff[adc_cfg_pkg::ctrl0_start_bit])
    else $error("completion effects missing");
  a_chan_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 sh_channel == $past(chan))
    else $error("channel not routed");
  a_drive_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ch_drv |=> core_drive_dig && core_dig_level == $past(ch_lvl))
    else $error("driven level not passed");
  a_resume_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done && adc_on && !wr_c0 |-> ##2 sh_sampling)
    else $error("sampling not resumed");
  a_ref_indep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl1_ff[1:0] == adc_cfg_pkg::nref_ext && $stable(ctrl1_ff) |=> neg_ext_en && !neg_gnd_en)
    else $error("negative reference wrong");
  a_pref_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl1_ff[3:2] == adc_cfg_pkg::pref_fixed && $stable(ctrl1_ff) |=> pos_fixed_en && !pos_vdd_en)
    else $error("positive reference wrong");
  a_strap_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !strap_done_ff |=> ans_b_ff == {8{$past(portb_analog_reset_config)}})
    else $error("strap not applied");

  // ****************************************
  // interrupt, sequencer, reference and pin checks
  // ****************************************
  // port b analog pins read low as port a does
  a_port_b_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == adc_cfg_pkg::port_b_addr |=> (reg_rdata & $past(ans_b_ff)) == 8'h00)
    else $error("port b analog pin read not low");
  a_irq_raised: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stat_ff[adc_cfg_pkg::irq_done_bit] && mask_ff[adc_cfg_pkg::irq_done_bit] && !wr_st |=> irq)
    else $error("unmasked flag without interrupt");
  a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mask_ff == 8'h00 |=> !irq)
    else $error("interrupt with all masked");
  a_busy_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_ff == sampling && adc_on && start |=> ##1 conv_busy)
    else $error("conversion did not start");
  a_result_taken: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done |=> state_ff == sampling && result_ff == $past(core_result))
    else $error("result not captured");
  // a strap reload after start-up would undo what software chose
  a_strap_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strap_done_ff && !wr_ab |=> $stable(ans_b_ff))
    else $error("port b select changed unasked");
  a_pref_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot({pos_vdd_en, pos_fixed_en, pos_ext_en}))
    else $error("positive reference not one-hot");
  a_nref_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot({neg_gnd_en, neg_ext_en}))
    else $error("negative reference not one-hot");
  a_pref_ext: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl1_ff[adc_cfg_pkg::pref_lsb +: adc_cfg_pkg::ref_width] == adc_cfg_pkg::pref_ext
      |=> pos_ext_en && !pos_vdd_en && !pos_fixed_en)
    else $error("external positive reference wrong");
  a_drive_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ch_drv |=> !core_drive_dig)
    else $error("input pin flagged as driven");
endmodule

// File: test/adc_far_side_model.sv
`timescale 1ns/1ps
module adc_far_side_model (
  // port pins
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pa_ext,
  input  wire logic [7:0] pb_ext,
  output logic      [7:0] pa_in,
  output logic      [7:0] pb_in,
  // analog core
  input  wire logic [4:0] sh_channel,
  input  wire logic       core_drive_dig,
  input  wire logic       core_dig_level,
  output logic      [9:0] core_result
);
  // ****************************************
  // pad levels
  // ****************************************
  // the pad driver wins over the outside source
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
  // ****************************************
  // converted level
  // ****************************************
  // converted input level
  // a driven pin converts its own rail; others give a channel-dependent level
  assign core_result = core_drive_dig ? {10{core_dig_level}} : ({sh_channel, 5'h0b} ^ 10'h155);
endmodule

// File: test/adc_input_and_reference_select_tb.sv
`timescale 1ns/1ps
module adc_input_and_reference_select_tb;
  localparam int conv_len = 4;
  logic       ref_clk, rst_n, strap, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe;
  logic [7:0] pa_dig_en, pb_dig_en, pa_ext, pb_ext, dir, lat, msk;
  logic [4:0] sh_channel, ch_sel;
  logic       sh_sampling, core_drive_dig, core_dig_level, conv_busy, irq;
  logic       pos_vdd_en, pos_fixed_en, pos_ext_en, neg_gnd_en, neg_ext_en;
  logic [9:0] core_result, res;
  int         seed, mismatches, samples_checked, cycles, i, j;

  adc_input_and_reference_select #(.conv_len(conv_len)) adc_input_and_reference_select_inst (
    .ref_clk, .rst_n, .portb_analog_reset_config(strap), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pa_in, .pb_in, .pa_out, .pa_oe, .pb_out, .pb_oe, .pa_dig_en,
    .pb_dig_en, .sh_channel, .sh_sampling, .core_drive_dig, .core_dig_level, .conv_busy,
    .core_result, .pos_vdd_en, .pos_fixed_en, .pos_ext_en, .neg_gnd_en, .neg_ext_en, .irq);
  adc_far_side_model adc_far_side_model_inst (
    .pa_out, .pa_oe, .pb_out, .pb_oe, .pa_ext, .pb_ext, .pa_in, .pb_in,
    .sh_channel, .core_drive_dig, .core_dig_level, .core_result);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [4:0] ref_exp(input logic [1:0] p, input logic [1:0] n);
    ref_exp = {p == adc_cfg_pkg::pref_vdd || p == 2'h3, p == adc_cfg_pkg::pref_fixed,
               p == adc_cfg_pkg::pref_ext, n != adc_cfg_pkg::nref_ext, n == adc_cfg_pkg::nref_ext};
  endfunction
  function automatic logic [9:0] conv_exp(input logic [4:0] c, input logic [7:0] dr,
                                          input logic [7:0] lt);
    conv_exp = dr[c[2:0]] ? ({c, 5'h0b} ^ 10'h155) : {10{lt[c[2:0]]}};
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // a hang counts against the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'hfca4;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    strap = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    pa_ext = 8'h00;
    pb_ext = 8'h00;
    for (j = 0; j < 2; j++) begin
      // reset and strap change on an edge, as every other input
      @(posedge ref_clk);
      rst_n <= 1'b0;
      strap <= (j == 0);
      repeat (12) @(posedge ref_clk);
      chk("refs in reset", {pos_vdd_en, pos_fixed_en, pos_ext_en, neg_gnd_en, neg_ext_en}, 5'h12);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rc(adc_cfg_pkg::portb_ans_addr, strap ? 8'hff : 8'h00, "portb ans");
      rc(adc_cfg_pkg::porta_ans_addr, adc_cfg_pkg::ans_a_rst, "porta ans");
      rc(adc_cfg_pkg::dir_a_addr, adc_cfg_pkg::dir_rst, "dir a");
    end
    rc(4'hf, 8'h00, "unmapped");
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      msk = $random(seed);
      pa_ext <= $random(seed);
      pb_ext <= $random(seed);
      wr(adc_cfg_pkg::porta_ans_addr, msk);
      wr(adc_cfg_pkg::portb_ans_addr, ~msk);
      repeat (5) @(posedge ref_clk);
      rc(adc_cfg_pkg::port_a_addr, pa_ext & ~msk, "port a");
      rc(adc_cfg_pkg::port_b_addr, pb_ext & msk, "port b");
      chk("dig en a", pa_dig_en, 8'(~msk));
      chk("dig en b", pb_dig_en, msk);
    end
    for (i = 0; i < 16; i++) begin
      wr(adc_cfg_pkg::ctrl1_addr, 8'(i));
      repeat (3) @(posedge ref_clk);
      chk("refs", {pos_vdd_en, pos_fixed_en, pos_ext_en, neg_gnd_en, neg_ext_en},
          ref_exp(2'(i >> 2), 2'(i)));
    end
    wr(adc_cfg_pkg::irq_mask_addr, 8'h01);
    for (i = 0; i < 12; i++) begin
      ch_sel = $random(seed);
      ch_sel[3] = 1'b0;
      dir = $random(seed);
      lat = $random(seed);
      wr(adc_cfg_pkg::dir_a_addr, dir);
      wr(adc_cfg_pkg::dir_b_addr, ~dir);
      wr(adc_cfg_pkg::lat_a_addr, lat);
      wr(adc_cfg_pkg::lat_b_addr, ~lat);
      wr(adc_cfg_pkg::porta_ans_addr, 8'($random(seed)));
      wr(adc_cfg_pkg::ctrl0_addr, {1'b0, ch_sel, 2'b01});
      repeat (2) @(posedge ref_clk);
      #1;
      chk("channel", sh_channel, ch_sel);
      chk("sampling", sh_sampling, 1'b1);
      chk("pins a", {pa_out, pa_oe}, {lat, 8'(~dir)});
      chk("pins b", {pb_out, pb_oe}, {8'(~lat), dir});
      chk("drive dig", core_drive_dig, !(ch_sel[4] ? !dir[ch_sel[2:0]] : dir[ch_sel[2:0]]));
      repeat (8) @(posedge ref_clk);
      wr(adc_cfg_pkg::ctrl0_addr, {1'b0, ch_sel, 2'b11});
      repeat (2) @(posedge ref_clk);
      #1;
      chk("conv starts", conv_busy, 1'b1);
      // busy stands conv_len cycles; look just after each edge so no update is raced
      for (j = 0; j < 100 && conv_busy !== 1'b0; j++) begin
        @(posedge ref_clk);
        #1;
      end
      chk("conv cycles", 16'(j), 16'(conv_len));
      repeat (2) @(posedge ref_clk);
      #1;
      chk("conv ends", conv_busy, 1'b0);
      chk("irq set", irq, 1'b1);
      chk("resampling", sh_sampling, 1'b1);
      rc(adc_cfg_pkg::ctrl0_addr, {1'b0, ch_sel, 2'b01}, "start cleared");
      rc(adc_cfg_pkg::irq_stat_addr, 8'h01, "done flag");
      res = conv_exp(ch_sel, ch_sel[4] ? ~dir : dir, ch_sel[4] ? ~lat : lat);
      rc(adc_cfg_pkg::result_addr, res[9:2], "result");
      if (i[0]) begin
        wr(adc_cfg_pkg::irq_mask_addr, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq masked", irq, 1'b0);
        wr(adc_cfg_pkg::irq_mask_addr, 8'h01);
      end
      wr(adc_cfg_pkg::irq_stat_addr, 8'h01);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irq cleared", irq, 1'b0);
      rc(adc_cfg_pkg::irq_stat_addr, 8'h00, "flag cleared");
    end
    stop_test();
  end
endmodule
